// [hw/at_bus_pkg.sv]
// shared constants, types and decode functions for the expansion bus front end
package at_bus_pkg;

  // timing, 40 MHz reference
  localparam int CLK_MHZ = 40;
  localparam int ALE_NS = 50;
  localparam int SETTLE_NS = 100;
  localparam int CMD_NS = 375;
  localparam int ZWS_NS = 175;
  localparam int HOLD_NS = 25;
  localparam int CS_NS = 100;
  localparam int DWELL_NS = 200;
  localparam int TURN_NS = 100;
  localparam int ALE_CYC = (ALE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CMD_CYC = (CMD_NS * CLK_MHZ + 999) / 1000;
  localparam int ZWS_CYC = (ZWS_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CS_CYC = (CS_NS * CLK_MHZ + 999) / 1000;
  localparam int DWELL_CYC = (DWELL_NS * CLK_MHZ + 999) / 1000;
  localparam int TURN_CYC = (TURN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 5;

  // address layout
  localparam int ADDR_W = 24;
  localparam int LA20_BIT = 20;
  localparam int SA0_BIT = 0;
  localparam int SA_HI = 19;
  localparam int SA_LO = 1;
  localparam logic [3:0] LOW_MEG_TOP = 4'h0;

  // two-way pin group, index into the pin vectors
  localparam int NPINS = 7;
  localparam int PIN_LA20 = 0;
  localparam int PIN_SA0 = 1;
  localparam int PIN_MEMR = 2;
  localparam int PIN_MEMW = 3;
  localparam int PIN_IOR = 4;
  localparam int PIN_IOW = 5;
  localparam int PIN_REFRESH = 6;

  // command bit positions, active high
  localparam int CMD_MEMR = 3;
  localparam int CMD_MEMW = 2;
  localparam int CMD_IOR = 1;
  localparam int CMD_IOW = 0;

  // multiplexer codes
  localparam logic [2:0] MUX_CLKDIR = 3'h4;
  localparam logic [2:0] MUX_BUSRST = 3'h4;
  localparam int CS_COUNT = 30;

  typedef enum logic [2:0] {
    K_MEM_RD = 3'b000,
    K_MEM_WR = 3'b001,
    K_IO_RD = 3'b010,
    K_IO_WR = 3'b011,
    K_DMA_IOR_MEMW = 3'b100,
    K_DMA_IOW_MEMR = 3'b101,
    K_REFRESH = 3'b110
  } cyc_kind_t;

  typedef struct packed {
    logic irqb;
    logic irqa;
    logic drq;
    logic master_n;
    logic memcs16_n;
    logic iocs16_n;
    logic zerows_n;
    logic iochrdy;
    logic [NPINS-1:0] bus;
  } dev_pins_t;

  typedef struct packed {
    logic [NPINS-1:0] bus;
    logic ale;
    logic cs;
    logic dack;
    logic dec_hi;
    logic dec_lo;
    logic [2:0] row;
    logic [2:0] mux;
    logic [SA_HI:SA_LO] sa;
  } far_pins_t;

  localparam dev_pins_t DEV_PINS_IDLE = '{irqb: 1'b0, irqa: 1'b0, drq: 1'b0,
    master_n: 1'b1, memcs16_n: 1'b1, iocs16_n: 1'b1, zerows_n: 1'b1,
    iochrdy: 1'b1, bus: {NPINS{1'b1}}};
  localparam far_pins_t FAR_PINS_IDLE = '{bus: {NPINS{1'b1}}, ale: 1'b0,
    cs: 1'b0, dack: 1'b0, dec_hi: 1'b0, dec_lo: 1'b0, row: 3'h0, mux: 3'h0, sa: '0};

  // strobes a kind asserts: {memr, memw, ior, iow}
  function automatic logic [3:0] cmd_of(input cyc_kind_t k);
    unique case (k)
      K_MEM_RD: cmd_of = 4'h8;
      K_MEM_WR: cmd_of = 4'h4;
      K_IO_RD: cmd_of = 4'h2;
      K_IO_WR: cmd_of = 4'h1;
      K_DMA_IOR_MEMW: cmd_of = 4'h6;
      K_DMA_IOW_MEMR: cmd_of = 4'h9;
      K_REFRESH: cmd_of = 4'h8;
      default: cmd_of = 4'h0;
    endcase
  endfunction

  function automatic logic is_io(input cyc_kind_t k);
    is_io = (k == K_IO_RD) || (k == K_IO_WR);
  endfunction

  function automatic logic is_dma(input cyc_kind_t k);
    is_dma = (k == K_DMA_IOR_MEMW) || (k == K_DMA_IOW_MEMR);
  endfunction

endpackage

// [hw/at_bus_if.sv]
// expansion bus wires between the controller end and the far end
`timescale 1ns/1ps
`default_nettype none
interface at_bus_if;
  import at_bus_pkg::*;

  logic [NPINS-1:0] dev_bus_out;
  logic [NPINS-1:0] dev_bus_oe;
  logic [NPINS-1:0] far_bus_out;
  logic [NPINS-1:0] far_bus_oe;
  logic [NPINS-1:0] bus;
  logic far_iochrdy_oe;
  logic iochrdy;
  logic zerows_n;
  logic iocs16_n;
  logic memcs16_n;
  logic master_n;
  logic ale;
  logic [SA_HI:SA_LO] sa_mid;
  logic aen;
  logic byte_swap_enable;
  logic low_megabyte_flag;
  logic [2:0] mux_select_out;
  logic chip_select_strobe;
  logic dma_ack_strobe;
  logic decode_high_line;
  logic decode_low_line;
  logic [2:0] row_addr_upper_lines;
  logic dma_request_mux_in;
  logic interrupt_group_a_in;
  logic interrupt_group_b_in;

  // wire levels, pulled high when nobody drives
  for (genvar i = 0; i < NPINS; i++)
  begin : g_pin
    assign bus[i] = dev_bus_oe[i] ? dev_bus_out[i] : (far_bus_oe[i] ? far_bus_out[i] : 1'b1);
  end
  assign iochrdy = !far_iochrdy_oe;

  modport dev (
    output dev_bus_out, dev_bus_oe, ale, sa_mid, aen, byte_swap_enable,
      low_megabyte_flag, mux_select_out, chip_select_strobe, dma_ack_strobe,
      decode_high_line, decode_low_line, row_addr_upper_lines,
    input bus, iochrdy, zerows_n, iocs16_n, memcs16_n, master_n,
      dma_request_mux_in, interrupt_group_a_in, interrupt_group_b_in
  );

  modport far (
    output far_bus_out, far_bus_oe, far_iochrdy_oe, zerows_n, iocs16_n,
      memcs16_n, master_n, dma_request_mux_in, interrupt_group_a_in,
      interrupt_group_b_in,
    input bus, ale, sa_mid, aen, byte_swap_enable, low_megabyte_flag,
      mux_select_out, chip_select_strobe, dma_ack_strobe, decode_high_line,
      decode_low_line, row_addr_upper_lines
  );
endinterface
`default_nettype wire

// [hw/pin_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb
  begin
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '{s1: INIT, s2: INIT};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;
endmodule
`default_nettype wire

// [hw/at_bus_cycle_control.sv]
// controller end of the expansion bus: cycles, strobes, multiplexer scan
`timescale 1ns/1ps
`default_nettype none
module at_bus_cycle_control
  import at_bus_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  at_bus_if.dev bus,
  input wire logic req_i,
  input wire cyc_kind_t kind_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [2:0] dma_chan_i,
  input wire logic cs_req_i,
  input wire logic [4:0] cs_code_i,
  input wire logic bus_reset_i,
  output logic ready_o,
  output logic done_o,
  output logic wide_o,
  output logic master_active_o,
  output logic [3:0] master_cmd_o,
  output logic master_la20_o,
  output logic master_sa0_o,
  output logic dram_refresh_o,
  output logic [7:0] drq_o,
  output logic [7:0] irq_a_o,
  output logic [7:0] irq_b_o
);

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_SETTLE = 3'b010,
    PH_CMD = 3'b011,
    PH_HOLD = 3'b100,
    PH_CSEL = 3'b101
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [CNT_W-1:0] cnt;
    cyc_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [2:0] dch;
    logic [4:0] csc;
    logic wide;
    logic ale;
    logic cmd_on;
    logic aen;
    logic refr;
    logic swap;
    logic low_meg;
    logic done;
    logic cs_on;
    logic dma_on;
    logic brst;
    logic [2:0] scan;
    logic [3:0] dwell;
    logic [7:0] drq;
    logic [7:0] irqa;
    logic [7:0] irqb;
    logic bm_ref;
    logic dram_ref;
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;
  dev_pins_t raw;
  dev_pins_t p;
  logic master;
  logic [3:0] cmd;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs through two flops
  assign raw = '{irqb: bus.interrupt_group_b_in, irqa: bus.interrupt_group_a_in,
    drq: bus.dma_request_mux_in, master_n: bus.master_n, memcs16_n: bus.memcs16_n,
    iocs16_n: bus.iocs16_n, zerows_n: bus.zerows_n, iochrdy: bus.iochrdy, bus: bus.bus};

  pin_sync #(
    .W($bits(dev_pins_t)),
    .INIT(DEV_PINS_IDLE)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(raw),
    .q_o(p)
  );

  assign master = !p.master_n;
  assign ready_o = (s.phase == PH_IDLE) && !master && !s.brst && !bus_reset_i;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.dram_ref = 1'b0;
    unique case (s.phase)
      PH_IDLE:
      begin
        next_s.brst = bus_reset_i && !master;
        if (ready_o && req_i)
        begin
          next_s.phase = PH_ADDR;
          next_s.cnt = '0;
          next_s.kind = kind_i;
          next_s.addr = addr_i;
          next_s.dch = dma_chan_i;
          next_s.ale = 1'b1;
          next_s.aen = is_dma(kind_i) || (kind_i == K_REFRESH);
          next_s.refr = (kind_i == K_REFRESH);
          next_s.dma_on = is_dma(kind_i);
          next_s.low_meg = (addr_i[ADDR_W-1:LA20_BIT] == LOW_MEG_TOP);
        end
        else if (ready_o && cs_req_i && (int'(cs_code_i) < CS_COUNT))
        begin
          next_s.phase = PH_CSEL;
          next_s.cnt = '0;
          next_s.csc = cs_code_i;
          next_s.cs_on = 1'b1;
        end
      end
      PH_ADDR:
      begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == CNT_W'(ALE_CYC - 1))
        begin
          next_s.ale = 1'b0;
          next_s.phase = PH_SETTLE;
          next_s.cnt = '0;
        end
      end
      PH_SETTLE:
      begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == CNT_W'(SETTLE_CYC - 1))
        begin
          next_s.wide = is_io(s.kind) ? !p.iocs16_n : !p.memcs16_n;
          next_s.swap = (is_io(s.kind) ? p.iocs16_n : p.memcs16_n)
            && s.addr[SA0_BIT] && (s.kind != K_REFRESH);
          next_s.cmd_on = 1'b1;
          next_s.phase = PH_CMD;
          next_s.cnt = '0;
        end
      end
      PH_CMD:
      begin
        if (s.cnt != '1)
        begin
          next_s.cnt = s.cnt + 1'b1;
        end
        if (p.iochrdy && ((s.cnt >= CNT_W'(CMD_CYC - 1)) ||
            (!p.zerows_n && (s.cnt >= CNT_W'(ZWS_CYC - 1)))))
        begin
          next_s.cmd_on = 1'b0;
          next_s.phase = PH_HOLD;
          next_s.cnt = '0;
        end
      end
      PH_HOLD:
      begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == CNT_W'(HOLD_CYC - 1))
        begin
          next_s.aen = 1'b0;
          next_s.refr = 1'b0;
          next_s.dma_on = 1'b0;
          next_s.swap = 1'b0;
          next_s.done = 1'b1;
          next_s.phase = PH_IDLE;
        end
      end
      PH_CSEL:
      begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == CNT_W'(CS_CYC - 1))
        begin
          next_s.cs_on = 1'b0;
          next_s.done = 1'b1;
          next_s.phase = PH_IDLE;
        end
      end
      default:
      begin
        next_s.phase = PH_IDLE;
      end
    endcase

    // multiplexer scan, paused while acks use the selects
    if (s.dma_on || s.brst)
    begin
      next_s.dwell = '0;
    end
    else if (s.dwell == 4'(DWELL_CYC - 1))
    begin
      next_s.drq[s.scan] = p.drq;
      next_s.irqa[s.scan] = p.irqa;
      next_s.irqb[s.scan] = p.irqb;
      next_s.scan = s.scan + 1'b1;
      next_s.dwell = '0;
    end
    else
    begin
      next_s.dwell = s.dwell + 1'b1;
    end

    // master refresh with memr
    next_s.bm_ref = master && !p.bus[PIN_REFRESH] && !p.bus[PIN_MEMR];
    if (next_s.bm_ref && !s.bm_ref)
    begin
      next_s.dram_ref = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  assign cmd = s.cmd_on ? cmd_of(s.kind) : 4'h0;

  always_comb
  begin
    bus.dev_bus_oe = {NPINS{!master}};
    bus.dev_bus_oe[PIN_REFRESH] = !master && s.refr;
    bus.dev_bus_out[PIN_LA20] = s.addr[LA20_BIT];
    bus.dev_bus_out[PIN_SA0] = s.addr[SA0_BIT];
    bus.dev_bus_out[PIN_MEMR] = !cmd[CMD_MEMR];
    bus.dev_bus_out[PIN_MEMW] = !cmd[CMD_MEMW];
    bus.dev_bus_out[PIN_IOR] = !cmd[CMD_IOR];
    bus.dev_bus_out[PIN_IOW] = !cmd[CMD_IOW];
    bus.dev_bus_out[PIN_REFRESH] = !s.refr;
  end

  assign bus.ale = s.ale;
  assign bus.sa_mid = s.addr[SA_HI:SA_LO];
  assign bus.aen = s.aen;
  assign bus.byte_swap_enable = s.swap;
  assign bus.low_megabyte_flag = s.low_meg;
  assign bus.dma_ack_strobe = s.dma_on || s.brst;
  assign bus.mux_select_out = s.brst ? MUX_BUSRST : (s.dma_on ? s.dch : s.scan);
  assign bus.chip_select_strobe = s.cs_on;
  assign {bus.decode_high_line, bus.decode_low_line, bus.row_addr_upper_lines} = s.csc;

  ////////////////////////////////////////////////////////////////////////////
  // user side
  assign done_o = s.done;
  assign wide_o = s.wide;
  assign master_active_o = master;
  assign master_cmd_o = master ? ~{p.bus[PIN_MEMR], p.bus[PIN_MEMW], p.bus[PIN_IOR],
    p.bus[PIN_IOW]} : 4'h0;
  assign master_la20_o = master && p.bus[PIN_LA20];
  assign master_sa0_o = master && p.bus[PIN_SA0];
  assign dram_refresh_o = s.dram_ref;
  assign drq_o = s.drq;
  assign irq_a_o = s.irqa;
  assign irq_b_o = s.irqb;
endmodule
`default_nettype wire

// [hw/at_bus_far_end.sv]
// far end: slave responses, bus master, external multiplexer and decoders
`timescale 1ns/1ps
`default_nettype none
module at_bus_far_end
  import at_bus_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  at_bus_if.far bus,
  input wire logic slave_wait_i,
  input wire logic slave_zws_i,
  input wire logic slave_io16_i,
  input wire logic slave_mem16_i,
  input wire logic bm_req_i,
  input wire logic bm_la20_i,
  input wire logic bm_sa0_i,
  input wire logic [3:0] bm_cmd_i,
  input wire logic bm_refresh_i,
  input wire logic [7:0] drq_i,
  input wire logic [7:0] irq_a_i,
  input wire logic [7:0] irq_b_i,
  output logic [SA_HI:SA_LO] latched_addr_o,
  output logic [7:0] dack_o,
  output logic bus_reset_o,
  output logic [CS_COUNT-1:0] chip_sel_o,
  output logic bm_driving_o
);

  typedef struct packed {
    logic [SA_HI:SA_LO] addr;
    logic [7:0] dack;
    logic brst;
    logic [CS_COUNT-1:0] chip;
    logic drq;
    logic irqa;
    logic irqb;
    logic rdy_oe;
    logic zws;
    logic io16;
    logic mem16;
    logic master;
    logic [CNT_W-1:0] turn;
    logic drive;
  } far_state_t;

  far_state_t s;
  far_state_t next_s;
  far_pins_t raw;
  far_pins_t q;
  logic [4:0] code;
  logic cmd_seen;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs through two flops
  assign raw = '{bus: bus.bus, ale: bus.ale, cs: bus.chip_select_strobe,
    dack: bus.dma_ack_strobe, dec_hi: bus.decode_high_line, dec_lo: bus.decode_low_line,
    row: bus.row_addr_upper_lines, mux: bus.mux_select_out, sa: bus.sa_mid};

  pin_sync #(
    .W($bits(far_pins_t)),
    .INIT(FAR_PINS_IDLE)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(raw),
    .q_o(q)
  );

  assign code = {q.dec_hi, q.dec_lo, q.row};
  assign cmd_seen = !(q.bus[PIN_MEMR] && q.bus[PIN_MEMW] && q.bus[PIN_IOR] && q.bus[PIN_IOW]);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_s = s;
    if (q.ale)
    begin
      next_s.addr = q.sa;
    end
    next_s.dack = '0;
    next_s.brst = 1'b0;
    if (q.dack)
    begin
      if (q.mux == MUX_BUSRST)
      begin
        next_s.brst = 1'b1;
      end
      else
      begin
        next_s.dack[q.mux] = 1'b1;
      end
    end
    next_s.chip = '0;
    if (q.cs && (int'(code) < CS_COUNT))
    begin
      next_s.chip[code] = 1'b1;
    end
    next_s.drq = drq_i[q.mux];
    next_s.irqa = irq_a_i[q.mux];
    next_s.irqb = irq_b_i[q.mux];
    next_s.rdy_oe = slave_wait_i && cmd_seen;
    next_s.zws = slave_zws_i && cmd_seen;
    next_s.io16 = slave_io16_i;
    next_s.mem16 = slave_mem16_i;
    // master waits for the controller to release before driving
    next_s.master = bm_req_i;
    if (!bm_req_i)
    begin
      next_s.turn = '0;
      next_s.drive = 1'b0;
    end
    else if (s.turn == CNT_W'(TURN_CYC - 1))
    begin
      next_s.drive = 1'b1;
    end
    else
    begin
      next_s.turn = s.turn + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  always_comb
  begin
    bus.far_bus_oe = {NPINS{s.drive && bm_req_i}};
    bus.far_bus_oe[PIN_REFRESH] = s.drive && bm_req_i && bm_refresh_i;
    bus.far_bus_out[PIN_LA20] = bm_la20_i;
    bus.far_bus_out[PIN_SA0] = bm_sa0_i;
    bus.far_bus_out[PIN_MEMR] = !bm_cmd_i[CMD_MEMR];
    bus.far_bus_out[PIN_MEMW] = !bm_cmd_i[CMD_MEMW];
    bus.far_bus_out[PIN_IOR] = !bm_cmd_i[CMD_IOR];
    bus.far_bus_out[PIN_IOW] = !bm_cmd_i[CMD_IOW];
    bus.far_bus_out[PIN_REFRESH] = 1'b0;
  end

  assign bus.far_iochrdy_oe = s.rdy_oe;
  assign bus.zerows_n = !s.zws;
  assign bus.iocs16_n = !s.io16;
  assign bus.memcs16_n = !s.mem16;
  assign bus.master_n = !s.master;
  assign bus.dma_request_mux_in = s.drq;
  assign bus.interrupt_group_a_in = s.irqa;
  assign bus.interrupt_group_b_in = s.irqb;

  assign latched_addr_o = s.addr;
  assign dack_o = s.dack;
  assign bus_reset_o = s.brst;
  assign chip_sel_o = s.chip;
  assign bm_driving_o = s.drive && bm_req_i;
endmodule
`default_nettype wire

// [verification/at_bus_asserts.sv]
// concurrent checks on the expansion bus wires between both ends
`timescale 1ns/1ps
`default_nettype none
module at_bus_asserts
  import at_bus_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [NPINS-1:0] dev_bus_oe,
  input wire logic [NPINS-1:0] bus,
  input wire logic master_n,
  input wire logic iochrdy,
  input wire logic iocs16_n,
  input wire logic memcs16_n,
  input wire logic ale,
  input wire logic aen,
  input wire logic low_megabyte_flag,
  input wire logic byte_swap_enable,
  input wire logic [2:0] mux_select_out,
  input wire logic chip_select_strobe,
  input wire logic dma_ack_strobe
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // any own command strobe low
  wire logic cmd_low = master_n && (bus[PIN_IOW:PIN_MEMR] != 4'hf);

  ////////////////////////////////////////
  master_release_a: assert property (!master_n [*3] |-> dev_bus_oe == '0)
    else $error("drivers kept in master mode");
  addr_drive_a: assert property ($rose(ale) |-> dev_bus_oe[PIN_SA0] && dev_bus_oe[PIN_LA20])
    else $error("address pins not driven");
  ale_pulse_a: assert property ($rose(ale) |=> ale ##1 !ale)
    else $error("ale pulse wrong");
  aen_io_a: assert property (cmd_low && bus[PIN_MEMW] && bus[PIN_MEMR] |-> !aen)
    else $error("aen in io cycle");
  refresh_aen_a: assert property (master_n && !bus[PIN_REFRESH] |-> aen)
    else $error("refresh without aen");
  dack_aen_a: assert property (dma_ack_strobe && mux_select_out != MUX_BUSRST |-> aen)
    else $error("dack without aen");
  dack_hold_a: assert property (dma_ack_strobe && $past(dma_ack_strobe)
    |-> $stable(mux_select_out))
    else $error("mux moved under dack");
  cs_len_a: assert property ($rose(chip_select_strobe)
    |-> chip_select_strobe [*4] ##1 !chip_select_strobe)
    else $error("chip select length");
  low_meg_a: assert property ($rose(ale) |-> !(low_megabyte_flag && bus[PIN_LA20]))
    else $error("low megabyte flag with la20");
  wait_hold_a: assert property (!iochrdy [*4] ##0 cmd_low |=> cmd_low)
    else $error("strobe ended during wait");
  cmd_min_a: assert property ($rose(cmd_low) |-> cmd_low [*7])
    else $error("strobe too short");
  swap_enable_a: assert property ($rose(cmd_low) && iocs16_n && memcs16_n && !aen
    |-> byte_swap_enable == bus[PIN_SA0])
    else $error("swap enable wrong");

  c_wait: cover property ($rose(cmd_low) ##3 !iochrdy);
  c_cs: cover property ($rose(chip_select_strobe));
  c_master: cover property (!master_n [*3]);
  c_busrst: cover property (dma_ack_strobe && mux_select_out == MUX_BUSRST);
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for both ends of the expansion bus
`timescale 1ns/1ps
`default_nettype none
module testbench
  import at_bus_pkg::*;
  ;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  cyc_kind_t kind_i = K_MEM_RD;
  logic [23:0] addr_i = '0;
  logic [2:0] dma_chan_i = '0;
  logic cs_req_i = 1'b0;
  logic [4:0] cs_code_i = '0;
  logic bus_reset_i = 1'b0;
  logic ready_o, done_o, wide_o, master_active_o, master_la20_o, master_sa0_o;
  logic dram_refresh_o, bus_reset_o, bm_driving_o;
  logic [3:0] master_cmd_o;
  logic [7:0] drq_o, irq_a_o, irq_b_o, dack_o;
  logic slave_wait_i = 1'b0;
  logic slave_zws_i = 1'b0;
  logic slave_io16_i = 1'b0;
  logic slave_mem16_i = 1'b0;
  logic bm_req_i = 1'b0;
  logic bm_la20_i = 1'b0;
  logic bm_sa0_i = 1'b0;
  logic bm_refresh_i = 1'b0;
  logic [3:0] bm_cmd_i = '0;
  logic [7:0] drq_i = '0;
  logic [7:0] irq_a_i = '0;
  logic [7:0] irq_b_i = '0;
  logic [SA_HI:SA_LO] latched_addr_o;
  logic [CS_COUNT-1:0] chip_sel_o;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 32'h6384_e41e;

  always #12.5 ref_clk_i = ~ref_clk_i;

  at_bus_if bus_if ();
  at_bus_cycle_control at_bus_cycle_control_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .bus(bus_if), .req_i(req_i), .kind_i(kind_i), .addr_i(addr_i), .dma_chan_i(dma_chan_i),
    .cs_req_i(cs_req_i), .cs_code_i(cs_code_i), .bus_reset_i(bus_reset_i), .ready_o(ready_o),
    .done_o(done_o), .wide_o(wide_o), .master_active_o(master_active_o),
    .master_cmd_o(master_cmd_o), .master_la20_o(master_la20_o), .master_sa0_o(master_sa0_o),
    .dram_refresh_o(dram_refresh_o), .drq_o(drq_o), .irq_a_o(irq_a_o), .irq_b_o(irq_b_o));
  at_bus_far_end at_bus_far_end_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus_if),
    .slave_wait_i(slave_wait_i), .slave_zws_i(slave_zws_i), .slave_io16_i(slave_io16_i),
    .slave_mem16_i(slave_mem16_i), .bm_req_i(bm_req_i), .bm_la20_i(bm_la20_i),
    .bm_sa0_i(bm_sa0_i), .bm_cmd_i(bm_cmd_i), .bm_refresh_i(bm_refresh_i), .drq_i(drq_i),
    .irq_a_i(irq_a_i), .irq_b_i(irq_b_i), .latched_addr_o(latched_addr_o), .dack_o(dack_o),
    .bus_reset_o(bus_reset_o), .chip_sel_o(chip_sel_o), .bm_driving_o(bm_driving_o));
  at_bus_asserts at_bus_asserts_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .dev_bus_oe(bus_if.dev_bus_oe), .bus(bus_if.bus), .master_n(bus_if.master_n),
    .iochrdy(bus_if.iochrdy), .iocs16_n(bus_if.iocs16_n), .memcs16_n(bus_if.memcs16_n),
    .ale(bus_if.ale), .aen(bus_if.aen), .low_megabyte_flag(bus_if.low_megabyte_flag),
    .byte_swap_enable(bus_if.byte_swap_enable), .mux_select_out(bus_if.mux_select_out),
    .chip_select_strobe(bus_if.chip_select_strobe), .dma_ack_strobe(bus_if.dma_ack_strobe));

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // {memr, memw, ior, iow} per cycle kind
  function automatic logic [3:0] exp_cmd(input cyc_kind_t k);
    case (k)
      K_MEM_RD, K_REFRESH: exp_cmd = 4'h8;
      K_MEM_WR: exp_cmd = 4'h4;
      K_IO_RD: exp_cmd = 4'h2;
      K_IO_WR: exp_cmd = 4'h1;
      K_DMA_IOR_MEMW: exp_cmd = 4'h6;
      default: exp_cmd = 4'h9;
    endcase
  endfunction

  task automatic run_cycle(input cyc_kind_t k, input logic [23:0] a, input logic [2:0] ch,
    input logic io16, input logic m16, input logic zws, input logic wt);
    int len;
    int n;
    logic [3:0] cmd;
    logic [7:0] dk;
    logic la20, sa0, low_meg, aen, refr, swap, w;
    len = 0;
    n = 0;
    dk = '0;
    aen = 1'b0;
    refr = 1'b0;
    @(negedge ref_clk_i);
    {kind_i, addr_i, dma_chan_i, slave_io16_i, slave_mem16_i} = {k, a, ch, io16, m16};
    {slave_zws_i, slave_wait_i, req_i} = {zws, wt, 1'b1};
    @(negedge ref_clk_i);
    req_i = 1'b0;
    while (done_o !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk_i);
      n++;
      if (bus_if.bus[PIN_IOW:PIN_MEMR] != 4'hf)
      begin
        len++;
        cmd = {<<{~bus_if.bus[PIN_IOW:PIN_MEMR]}};
        {la20, sa0} = {bus_if.bus[PIN_LA20], bus_if.bus[PIN_SA0]};
        {low_meg, swap} = {bus_if.low_megabyte_flag, bus_if.byte_swap_enable};
      end
      if (len == 20)
        slave_wait_i = 1'b0;
      aen |= bus_if.aen;
      refr |= !bus_if.bus[PIN_REFRESH];
      dk |= dack_o;
    end
    w = (k == K_IO_RD || k == K_IO_WR) ? io16 : m16;
    check(n < 200, 1'b1);
    check(cmd, exp_cmd(k));
    check(la20, a[20]);
    check(sa0, a[0]);
    check(low_meg, a[23:20] == 4'h0);
    check(aen, k >= K_DMA_IOR_MEMW);
    check(refr, k == K_REFRESH);
    check(latched_addr_o, a[19:1]);
    check(dk, (k == K_DMA_IOR_MEMW || k == K_DMA_IOW_MEMR) ? 8'h01 << ch : 8'h00);
    if (k < K_DMA_IOR_MEMW)
    begin
      check(wide_o, w);
      check(swap, a[0] && !w);
    end
    check(wt ? len > 15 : (zws ? len >= 7 && len < 15 : len == 15), 1'b1);
  endtask

  task automatic run_master(input logic [3:0] c, input logic la, input logic s0, input logic rf);
    int pulses;
    pulses = 0;
    @(negedge ref_clk_i);
    {bm_cmd_i, bm_la20_i, bm_sa0_i, bm_refresh_i, bm_req_i} = {c, la, s0, rf, 1'b1};
    repeat (12)
    begin
      @(negedge ref_clk_i);
      pulses += dram_refresh_o;
    end
    check(bus_if.dev_bus_oe, '0);
    check({master_active_o, bm_driving_o}, 2'b11);
    check(master_cmd_o, c);
    check({master_la20_o, master_sa0_o}, {la, s0});
    check(pulses, rf && c[3]);
    {bm_cmd_i, bm_refresh_i} = 5'h00;
    repeat (6) @(negedge ref_clk_i);
    bm_req_i = 1'b0;
    repeat (12) @(negedge ref_clk_i);
    check(ready_o, 1'b1);
  endtask

  task automatic run_cs(input logic [4:0] code);
    logic [29:0] seen;
    int n;
    seen = '0;
    n = 0;
    @(negedge ref_clk_i);
    {cs_code_i, cs_req_i} = {code, 1'b1};
    @(negedge ref_clk_i);
    cs_req_i = 1'b0;
    repeat (10)
    begin
      @(negedge ref_clk_i);
      seen |= chip_sel_o;
      n += done_o;
    end
    check(seen, code < 30 ? 30'h1 << code : 30'h0);
    check(n, code < 30);
  endtask

  ////////////////////////////////////////
  initial
  begin
    cyc_kind_t k;
    logic [2:0] ch;
    logic rst_seen;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    run_cycle(K_MEM_RD, 24'h0f_ffff, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    run_cycle(K_MEM_WR, 24'h10_0000, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    run_cycle(K_IO_WR, 24'h00_0301, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    run_cycle(K_IO_RD, 24'h00_0300, 3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 21; i++)
    begin
      k = cyc_kind_t'(i % 7);
      ch = 3'($random(seed));
      if (ch == 3'h4)
        ch = 3'h5;
      run_cycle(k, 24'($random(seed)), ch, 1'($random(seed)), 1'($random(seed)),
        1'($random(seed)), 1'($random(seed)));
    end
    $display("test cycles done");
    run_master(4'h8, 1'b1, 1'b1, 1'b1);
    run_master(4'($random(seed)), 1'b0, 1'b1, 1'b0);
    $display("test master done");
    for (int i = 0; i < 2; i++)
    begin
      @(negedge ref_clk_i);
      {drq_i, irq_a_i, irq_b_i} = 24'($random(seed));
      repeat (160) @(negedge ref_clk_i);
      check(drq_o, drq_i);
      check(irq_a_o, irq_a_i);
      check(irq_b_o, irq_b_i);
    end
    $display("test scan done");
    for (int c = 0; c < 32; c++)
      run_cs(5'(c));
    $display("test chip select done");
    rst_seen = 1'b0;
    @(negedge ref_clk_i);
    bus_reset_i = 1'b1;
    repeat (8)
    begin
      @(negedge ref_clk_i);
      rst_seen |= bus_reset_o;
    end
    bus_reset_i = 1'b0;
    check(rst_seen, 1'b1);
    $display("test bus reset done");
    complete_run();
  end

  // about 1500 cycles expected, cut off at 20000
  initial
  begin
    #500000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
